/* tb/spgc_board.sv */
// Board model on the host data pins.
// Assumes oe_n low means the block owns the pin.
`timescale 1ns/100ps
`default_nettype none
module spgc_board (
  // Pins
  input wire logic [7:0] oe_n, out, drv,
  output logic [7:0] pins
);
  // One driver per pin, never both, so no contention
  assign pins = (oe_n & drv) | (~oe_n & out);
endmodule : spgc_board
`default_nettype wire

/* tb/spgc_gpio_sva.sv */
// Port assertions for spgc_gpio.
// Assumes one clock and the package constants.
`timescale 1ns/100ps
`default_nettype none
module spgc_gpio_sva
  import spgc_pkg::*;
(
  input wire logic clk_sys, rst_n, mmr_wr, mmr_rd, host_port_enable, host_port_wide_mode,
  input wire logic serial_rx_in_reset, serial_tx_in_reset, host_gpio_active,
  input wire logic [15:0] mmr_addr, mmr_wdata, mmr_rdata,
  input wire logic [12:0] serial_gpio_rx_mask, serial_gpio_allowed,
  input wire logic [7:0] host_port_data_pins_out, host_port_data_pins_oe_n
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_wr(a);
    mmr_wr && mmr_addr == a;
  endsequence
  a_id_value: assert property (mmr_rd && mmr_addr == SPGC_ADDR_ID |=>
    mmr_rdata == {8'h00, SPGC_CHIP_REV, 4'h0}) else $error("id bad");
  a_status_upper: assert property (mmr_rd && mmr_addr == SPGC_ADDR_STATUS |=>
    mmr_rdata[15:8] == 8'h00) else $error("status upper bad");
  a_unmapped_zero: assert property (mmr_rd && !(mmr_addr inside {[16'h003c:16'h003e]})
    |=> mmr_rdata == 16'h0000) else $error("unmapped bad");
  a_rdata_hold: assert property (!mmr_rd |=> $stable(mmr_rdata)) else $error("rdata moved");
  a_host_idle: assert property (host_port_enable && !host_port_wide_mode |=>
    !host_gpio_active) else $error("gpio on");
  a_host_gpio: assert property (!host_port_enable || host_port_wide_mode |=>
    host_gpio_active) else $error("gpio off");
  a_pins_released: assert property (!host_gpio_active |=>
    host_port_data_pins_oe_n == 8'hff) else $error("pin driven");
  a_dir_oe: assert property (s_wr(SPGC_ADDR_DIR) ##1 host_gpio_active |=>
    host_port_data_pins_oe_n == ~$past(mmr_wdata[7:0], 2)) else $error("oe bad");
  a_out_value: assert property (s_wr(SPGC_ADDR_STATUS) |-> ##2
    (host_port_data_pins_out | host_port_data_pins_oe_n) ==
    ($past(mmr_wdata[7:0], 2) | host_port_data_pins_oe_n)) else $error("out bad");
  a_serial_allow: assert property (1'b1 |=> serial_gpio_allowed ==
    (($past(serial_gpio_rx_mask) & {13{$past(serial_rx_in_reset)}}) |
    (~$past(serial_gpio_rx_mask) & {13{$past(serial_tx_in_reset)}}))) else $error("serial bad");
endmodule : spgc_gpio_sva
bind spgc_gpio spgc_gpio_sva chk (.clk_sys(clk_sys), .rst_n(rst_n), .mmr_wr(mmr_wr),
  .mmr_rd(mmr_rd), .host_port_enable(host_port_enable),
  .host_port_wide_mode(host_port_wide_mode), .serial_rx_in_reset(serial_rx_in_reset),
  .serial_tx_in_reset(serial_tx_in_reset), .host_gpio_active(host_gpio_active),
  .mmr_addr(mmr_addr), .mmr_wdata(mmr_wdata), .mmr_rdata(mmr_rdata),
  .serial_gpio_rx_mask(serial_gpio_rx_mask), .serial_gpio_allowed(serial_gpio_allowed),
  .host_port_data_pins_out(host_port_data_pins_out),
  .host_port_data_pins_oe_n(host_port_data_pins_oe_n));
`default_nettype wire

/* tb/spgc_gpio_test.sv */
// Self-checking bench for spgc_gpio.
// Assumes the board model drives each released pin.
`timescale 1ns/100ps
`default_nettype none
module spgc_gpio_test;
  import spgc_pkg::*;
  localparam logic [15:0] ID = {8'h00, SPGC_CHIP_REV, 4'h0};
  logic clk_sys = 0, rst_n = 0, mmr_wr = 0, mmr_rd = 0;
  logic host_port_enable = 0, host_port_wide_mode = 0, host_gpio_active;
  logic serial_rx_in_reset = 0, serial_tx_in_reset = 0;
  logic [15:0] mmr_addr = '0, mmr_wdata = '0, mmr_rdata;
  logic [12:0] serial_gpio_rx_mask = 13'h00ff, serial_gpio_dir_req = '0, serial_gpio_allowed;
  logic [7:0] host_port_data_pins_in, host_port_data_pins_out, host_port_data_pins_oe_n;
  int failures = 0, n_compared = 0, cyc = 0;
  // Write flag, address, then write data or expected read data
  logic [32:0] rows [12] = '{{1'b0, 16'h003c, 16'h0000}, {1'b0, 16'h003e, ID},
    {1'b1, 16'h003e, 16'hffff}, {1'b0, 16'h003e, ID}, {1'b0, 16'h003f, 16'h0000},
    {1'b0, 16'h003d, 16'h00a5}, {1'b1, 16'h003c, 16'h00ff}, {1'b0, 16'h003c, 16'h00ff},
    {1'b0, 16'h003d, 16'h0000}, {1'b1, 16'h003c, 16'h00f0}, {1'b1, 16'h003d, 16'hff3c},
    {1'b0, 16'h003d, 16'h0035}};
  spgc_gpio DUT (.clk_sys(clk_sys), .rst_n(rst_n), .mmr_addr(mmr_addr), .mmr_wr(mmr_wr),
    .mmr_rd(mmr_rd), .mmr_wdata(mmr_wdata), .mmr_rdata(mmr_rdata),
    .host_port_enable(host_port_enable), .host_port_wide_mode(host_port_wide_mode),
    .host_port_data_pins_in(host_port_data_pins_in),
    .host_port_data_pins_out(host_port_data_pins_out),
    .host_port_data_pins_oe_n(host_port_data_pins_oe_n),
    .serial_rx_in_reset(serial_rx_in_reset), .serial_tx_in_reset(serial_tx_in_reset),
    .serial_gpio_rx_mask(serial_gpio_rx_mask), .serial_gpio_dir_req(serial_gpio_dir_req),
    .serial_gpio_allowed(serial_gpio_allowed), .host_gpio_active(host_gpio_active));
  spgc_board board (.oe_n(host_port_data_pins_oe_n), .out(host_port_data_pins_out),
    .drv(8'ha5), .pins(host_port_data_pins_in));
  always #10 clk_sys = ~clk_sys;
  task report_and_stop;
    if (failures == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : report_and_stop
  task chk(string nm, logic [15:0] got, logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task wr(logic [15:0] a, logic [15:0] d);
    @(negedge clk_sys);
    {mmr_addr, mmr_wdata, mmr_wr} = {a, d, 1'b1};
    @(negedge clk_sys);
    mmr_wr = 0;
  endtask : wr
  task rd(logic [15:0] a, logic [15:0] e);
    @(negedge clk_sys);
    {mmr_addr, mmr_rd} = {a, 1'b1};
    @(negedge clk_sys);
    mmr_rd = 0;
    chk("rdata", mmr_rdata, e);
  endtask : rd
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      failures++;
      report_and_stop;
    end
  end
  initial
  begin
    repeat (12) @(negedge clk_sys);
    rst_n = 1;
    foreach (rows[i])
      if (rows[i][32]) wr(rows[i][31:16], rows[i][15:0]);
      else rd(rows[i][31:16], rows[i][15:0]);
    chk("oe_n", host_port_data_pins_oe_n, 8'h0f);
    chk("pins", host_port_data_pins_in, 8'h35);
    chk("out", host_port_data_pins_out, 8'h3c);
    chk("active", host_gpio_active, 1'b1);
    host_port_enable = 1;
    repeat (3) @(negedge clk_sys);
    chk("oe_n", host_port_data_pins_oe_n, 8'hff);
    chk("active", host_gpio_active, 1'b0);
    host_port_wide_mode = 1;
    repeat (3) @(negedge clk_sys);
    chk("oe_n", host_port_data_pins_oe_n, 8'h0f);
    chk("active", host_gpio_active, 1'b1);
    serial_rx_in_reset = 1;
    repeat (2) @(negedge clk_sys);
    chk("allowed", serial_gpio_allowed, 13'h00ff);
    {serial_rx_in_reset, serial_tx_in_reset} = 2'b01;
    repeat (2) @(negedge clk_sys);
    chk("allowed", serial_gpio_allowed, 13'h1f00);
    rst_n = 0;
    @(negedge clk_sys);
    chk("oe_n", host_port_data_pins_oe_n, 8'hff);
    report_and_stop;
  end
endmodule : spgc_gpio_test
`default_nettype wire

/* verilog/spgc_gpio.sv */
// Shared-pin GPIO and chip identification registers.
// Assumes a single-cycle memory-mapped data bus on clk_sys; read data is
// registered and valid the cycle after a read strobe.
//
// Functional notes
// - GPIO use of a shared pin only while its primary function is idle.
// - Thirteen serial pins and eight host data pins are GPIO candidates.
// - Serial pins become GPIO only while their section is held in reset.
// - Host data pins are GPIO when host port disabled or in wide mode.
// - One direction bit per host data pin selects input or output.
// - Status bits 7..0 read/write, reset 0; bits 15..8 read 0.
// - Direction register at word 003Ch, status at the next word.
// - Read-only identification register; writes ignored.
// - Chip revision code in identification bits 7..4.
// - Subsystem code in bits 3..0, single-core value.
`timescale 1ns/100ps
`default_nettype none
module spgc_gpio (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Memory-mapped register port
  input wire logic [spgc_pkg::SPGC_ADDR_W-1:0] mmr_addr,
  input wire logic mmr_wr,
  input wire logic mmr_rd,
  input wire logic [spgc_pkg::SPGC_DATA_W-1:0] mmr_wdata,
  output logic [spgc_pkg::SPGC_DATA_W-1:0] mmr_rdata,
  // Host port mode
  input wire logic host_port_enable,
  input wire logic host_port_wide_mode,
  // Host data pins (oe low = driving)
  input wire logic [spgc_pkg::SPGC_PINS-1:0] host_port_data_pins_in,
  output logic [spgc_pkg::SPGC_PINS-1:0] host_port_data_pins_out,
  output logic [spgc_pkg::SPGC_PINS-1:0] host_port_data_pins_oe_n,
  // Serial-port pins and section resets
  input wire logic serial_rx_in_reset,
  input wire logic serial_tx_in_reset,
  input wire logic [spgc_pkg::SPGC_SERIAL_PINS-1:0] serial_gpio_rx_mask,
  input wire logic [spgc_pkg::SPGC_SERIAL_PINS-1:0] serial_gpio_dir_req,
  output logic [spgc_pkg::SPGC_SERIAL_PINS-1:0] serial_gpio_allowed,
  // Host port GPIO availability
  output logic host_gpio_active
);
  import spgc_pkg::*;

  // Register state
  logic [SPGC_PINS-1:0] dir;
  logic [SPGC_PINS-1:0] level_out;
  logic [SPGC_PINS-1:0] next_dir;
  logic [SPGC_PINS-1:0] next_level_out;
  // Address decode
  logic sel_dir;
  logic sel_status;
  logic sel_id;
  logic wr_dir;
  logic wr_status;
  // Read path
  logic [SPGC_PINS-1:0] status_view;
  logic [SPGC_DATA_W-1:0] id_word;
  logic [SPGC_DATA_W-1:0] next_rdata;
  // Pin path and mode
  logic [SPGC_PINS-1:0] pin_sync;
  logic gpio_mode;
  logic next_gpio_mode;
  logic [SPGC_PINS-1:0] next_oe_n;
  logic [SPGC_PINS-1:0] next_pins_out;
  // Serial pins
  logic [SPGC_SERIAL_PINS-1:0] serial_offer;
  logic [SPGC_SERIAL_PINS-1:0] next_serial_allowed;

  // Pin levels cross into clk_sys before anything reads them
  spgc_sync #(
    .WIDTH(SPGC_PINS)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .async_in(host_port_data_pins_in),
    .sync_out(pin_sync)
  );

  // Full 16-bit compare; aliases would shadow neighbouring peripherals
  always_comb
  begin
    sel_dir = (mmr_addr == SPGC_ADDR_DIR);
    sel_status = (mmr_addr == SPGC_ADDR_STATUS);
    sel_id = (mmr_addr == SPGC_ADDR_ID);
    wr_dir = mmr_wr && sel_dir;
    wr_status = mmr_wr && sel_status;
  end

  // Register group; the ID word has no write enable at all
  always_comb
  begin
    next_dir = dir;
    next_level_out = level_out;
    if (wr_dir)
    begin
      next_dir = mmr_wdata[SPGC_PINS-1:0];
    end
    if (wr_status)
    begin
      next_level_out = mmr_wdata[SPGC_LEVEL_LSB +: SPGC_PINS];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dir <= SPGC_DIR_RESET;
      level_out <= SPGC_STATUS_RESET;
    end
    else
    begin
      dir <= next_dir;
      level_out <= next_level_out;
    end
  end

  // Mode group
  always_comb
  begin
    next_gpio_mode = !host_port_enable || host_port_wide_mode;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gpio_mode <= 1'b0;
      host_gpio_active <= 1'b0;
    end
    else
    begin
      gpio_mode <= next_gpio_mode;
      host_gpio_active <= next_gpio_mode;
    end
  end

  // Each pin: 1 = output, 0 = input; inputs read the synchronised level
  genvar gi;
  generate
    for (gi = 0; gi < SPGC_PINS; gi++)
    begin : g_pin
      assign status_view[gi] = dir[gi] ? level_out[gi] : pin_sync[gi];
      assign next_oe_n[gi] = !(gpio_mode && dir[gi]);
      assign next_pins_out[gi] = level_out[gi];
    end
  endgenerate

  // Pins stay released through reset, so nothing fights the board
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      host_port_data_pins_oe_n <= 8'hff;
      host_port_data_pins_out <= 8'h00;
    end
    else
    begin
      host_port_data_pins_oe_n <= next_oe_n;
      host_port_data_pins_out <= next_pins_out;
    end
  end

  // Serial pins are offered only while their owning section sits in reset
  generate
    for (gi = 0; gi < SPGC_SERIAL_PINS; gi++)
    begin : g_ser
      assign serial_offer[gi] = serial_gpio_rx_mask[gi] ? serial_rx_in_reset
                                                         : serial_tx_in_reset;
    end
  endgenerate

  // A direction request never widens what the section reset allows
  always_comb
  begin
    next_serial_allowed = (serial_offer & serial_gpio_dir_req) | serial_offer;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      serial_gpio_allowed <= 13'h0000;
    end
    else
    begin
      serial_gpio_allowed <= next_serial_allowed;
    end
  end

  // Read group; upper byte is reserved and reads zero
  assign id_word = {8'h00, SPGC_CHIP_REV, SPGC_SUBSYS_SINGLE};

  always_comb
  begin
    next_rdata = mmr_rdata;
    if (mmr_rd)
    begin
      if (sel_dir)
      begin
        next_rdata = {8'h00, dir};
      end
      else if (sel_status)
      begin
        next_rdata = {8'h00, status_view};
      end
      else if (sel_id)
      begin
        next_rdata = id_word;
      end
      else
      begin
        next_rdata = 16'h0000;
      end
    end
  end

  // Read data holds between reads, so a slow reader is safe
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mmr_rdata <= 16'h0000;
    end
    else
    begin
      mmr_rdata <= next_rdata;
    end
  end
endmodule : spgc_gpio
`default_nettype wire

/* verilog/spgc_pkg.sv */
// Package for the shared-pin GPIO and chip identification block.
// Assumes a 16-bit memory-mapped data bus with word addresses.
package spgc_pkg;
  localparam int SPGC_ADDR_W = 16;
  localparam int SPGC_DATA_W = 16;
  localparam int SPGC_PINS = 8;
  localparam int SPGC_SERIAL_PINS = 13;
  // Word addresses of the registers
  localparam logic [15:0] SPGC_ADDR_DIR = 16'h003c;
  localparam logic [15:0] SPGC_ADDR_STATUS = 16'h003d;
  localparam logic [15:0] SPGC_ADDR_ID = 16'h003e;
  // Field positions
  localparam int SPGC_LEVEL_LSB = 0;
  localparam int SPGC_REV_LSB = 4;
  localparam int SPGC_SUB_LSB = 0;
  // Reset values
  localparam logic [7:0] SPGC_DIR_RESET = 8'h00;
  localparam logic [7:0] SPGC_STATUS_RESET = 8'h00;
  // Arbitrary revision code, not tied to any real part
  localparam logic [3:0] SPGC_CHIP_REV = 4'h1;
  // Single-core subsystem code
  localparam logic [3:0] SPGC_SUBSYS_SINGLE = 4'h0;
endpackage : spgc_pkg

/* verilog/spgc_sync.sv */
// Two-flop synchroniser for a vector of pin levels.
// Assumes inputs are asynchronous to clk_sys.
`timescale 1ns/100ps
`default_nettype none
module spgc_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_sync_out;

  always_comb
  begin
    next_stage1 = async_in;
    next_sync_out = stage1;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage1 <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1 <= next_stage1;
      sync_out <= next_sync_out;
    end
  end
endmodule : spgc_sync
`default_nettype wire
